// File: contact_inputs_model.sv
`timescale 1ns/1ns
`default_nettype none
// =====================================================
// isolated contacts on the far side
module contact_inputs_model (
  input  wire logic       clk_in,    // core clock
  output var  logic       go_out,    // go contact
  output var  logic       clear_out, // timer clear contact
  output var  logic [2:0] group_out  // group contacts
);
  // contacts open at power-up so nothing starts during reset
  initial begin
    go_out = 1'b0;
    clear_out = 1'b0;
    group_out = 3'h0;
  end
  // contacts move on the falling edge only, clear of sampling
  task automatic apply(input logic go, input logic clr, input logic [2:0] grp);
    @(negedge clk_in);
    go_out = go;
    clear_out = clr;
    group_out = grp;
  endtask
endmodule
`default_nettype wire

// File: run_seq_sva.sv
`timescale 1ns/1ns
`default_nettype none
// =====================================================
// sequencer port checks
module run_seq_sva #(
  parameter longint unsigned SEC_CYCLES = sched_run_pkg::SECOND_CYCLES // tick length
) (
  input wire logic                        clk_in,                   // clock
  input wire logic                        rst_in,                   // sync reset
  input wire logic [2:0]                  operating_mode_select_in, // mode
  input wire logic                        program_go_line_in,       // go
  input wire logic                        timer_clear_line_in,      // timer clear
  input wire logic [2:0]                  group_select_in,          // groups
  input wire logic                        point_write_in,           // point write
  input wire sched_run_pkg::point_entry_t point_entry_in,           // raw entry
  input wire logic                        mode_switch_in,           // switch request
  input wire logic                        entry_error_out,          // entry error
  input wire logic                        time_up_flag_out,         // time up
  input wire logic [2:0]                  group_active_out,         // running group
  input wire sched_run_pkg::tod_t         ref_time_out,             // reference time
  input wire logic                        external_mode_out,        // operation source
  input wire logic                        current_setting_out,      // gated input
  input wire logic                        inch_out                  // gated input
);
  import sched_run_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // a start needs the go and group pair to rise, never while clear holds
  sequence start_req;
    operating_mode_select_in == MODE_SCHEDULED && program_go_line_in
      && (|group_select_in) && !timer_clear_line_in
      && !$past(program_go_line_in && (|group_select_in));
  endsequence
  sequence run_begun;
    $onehot(group_active_out) && !time_up_flag_out;
  endsequence
  a_start_run: assert property (start_req |=> run_begun)
    else $error("run did not start on go");
  a_ref_clear: assert property (timer_clear_line_in |-> ##2 ref_time_out == TOD_ZERO)
    else $error("reference time not cleared");
  a_clear_idles: assert property (timer_clear_line_in |=> !time_up_flag_out &&
    group_active_out == 3'h0) else $error("clear left sequencer busy");
  a_group_onehot: assert property ($onehot0(group_active_out))
    else $error("more than one group active");
  a_mode_gate: assert property (operating_mode_select_in == MODE_SCHEDULED
    |=> !current_setting_out && !inch_out) else $error("ignored input passed");
  a_minor_reject: assert property (point_write_in && point_entry_in.minor_code > MINOR_MAX
    && point_entry_in.major_code != EMPTY_MARK |=> entry_error_out)
    else $error("minor over 59 accepted");
  a_freq_reject: assert property (point_write_in && point_entry_in.freq_code > FREQ_MAX
    && point_entry_in.freq_code != EMPTY_MARK && point_entry_in.dir_code != EMPTY_MARK
    |=> entry_error_out) else $error("frequency over range accepted");
  a_switch_refused: assert property (mode_switch_in && (program_go_line_in
    || timer_clear_line_in) |=> $stable(external_mode_out)) else $error("mode switched");
endmodule
bind scheduled_run_sequencer run_seq_sva #(.SEC_CYCLES(SEC_CYCLES)) chk_u (
  .clk_in(clk_in), .rst_in(rst_in), .operating_mode_select_in(operating_mode_select_in),
  .program_go_line_in(program_go_line_in), .timer_clear_line_in(timer_clear_line_in),
  .group_select_in(group_select_in), .point_write_in(point_write_in),
  .point_entry_in(point_entry_in), .mode_switch_in(mode_switch_in),
  .entry_error_out(entry_error_out), .time_up_flag_out(time_up_flag_out),
  .group_active_out(group_active_out), .ref_time_out(ref_time_out),
  .external_mode_out(external_mode_out), .current_setting_out(current_setting_out),
  .inch_out(inch_out)
);
`default_nettype wire

// File: sched_run_pkg.sv
package sched_run_pkg;

  // =====================================================================
  // timing
  localparam longint unsigned CLK_PERIOD_NS  = 64'd4;           // 250 MHz core clock
  localparam longint unsigned SECOND_TIME_NS = 64'd1000000000;  // one second of time of day
  localparam longint unsigned SECOND_CYCLES  = SECOND_TIME_NS / CLK_PERIOD_NS;
  localparam int              MINOR_PER_MAJOR = 60;             // carry minor into major at 60

  // =====================================================================
  // schedule layout and value limits
  localparam int          GROUPS        = 3;
  localparam int          GROUP_POINTS  = 10;
  localparam int          POINTS        = GROUPS * GROUP_POINTS;
  localparam logic [13:0] EMPTY_MARK    = 14'd9999;   // unprogrammed marker
  localparam logic [13:0] DIR_MAX       = 14'd2;
  localparam logic [13:0] FREQ_MAX      = 14'd4000;   // 400.0 Hz in 0.1 Hz steps
  localparam logic [13:0] MAJOR_MAX     = 14'd99;
  localparam logic [13:0] MINOR_MAX     = 14'd59;
  localparam logic [6:0]  TOD_MAJOR_MAX = 7'd99;
  localparam logic [5:0]  TOD_MINOR_MAX = 6'd59;
  localparam logic [2:0]  MODE_SCHEDULED = 3'd5;

  // =====================================================================
  // encodings
  localparam logic [1:0] DIR_STOP = 2'd0;
  localparam logic [1:0] DIR_FWD  = 2'd1;
  localparam logic [1:0] DIR_REV  = 2'd2;
  localparam int UNIT_HOUR_BIT    = 0;  // unit select bit0: hour:minute
  localparam int UNIT_MON_BIT     = 1;  // unit select bit1: show reference time

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_DONE = 3'b100
  } seq_state_t;

  typedef struct packed {
    logic [6:0] major;
    logic [5:0] minor;
  } tod_t;

  typedef struct packed {
    logic        set_empty;
    logic        time_empty;
    logic [1:0]  dir;
    logic [11:0] freq;
    tod_t        at;
  } point_t;

  // raw entry values as typed at the keypad, 9999 meaning empty
  typedef struct packed {
    logic [13:0] dir_code;
    logic [13:0] freq_code;
    logic [13:0] major_code;
    logic [13:0] minor_code;
  } point_entry_t;

  typedef struct packed {
    logic [1:0]  dir;
    logic [11:0] freq;
  } drive_cmd_t;

  localparam point_t POINT_RESET = '{set_empty: 1'b1, time_empty: 1'b1, dir: 2'd0,
                                     freq: 12'd0, at: '{major: 7'd0, minor: 6'd0}};
  localparam tod_t   TOD_ZERO    = '{major: 7'd0, minor: 6'd0};

endpackage

// File: scheduled_run_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
// =====================================================================

module scheduled_run_sequencer #(
  parameter longint unsigned SEC_CYCLES = sched_run_pkg::SECOND_CYCLES // shorten in sim
) (
  input  wire logic                        clk_in,                // 250 MHz clock
  input  wire logic                        rst_in,                // sync reset, high
  input  wire logic [2:0]                  operating_mode_select_in, // 5 = scheduled run
  input  wire logic [1:0]                  time_unit_select_in,   // unit / monitor select
  input  wire logic                        program_go_line_in,    // go input
  input  wire logic                        timer_clear_line_in,   // timer clear input
  input  wire logic [2:0]                  group_select_in,       // bit0 group one..bit2 three
  input  wire logic                        drive_reset_in,        // drive reset input
  input  wire logic                        power_loss_in,         // power-off indication
  input  wire logic                        fault_clear_line_in,   // fault clear input
  input  wire logic                        drive_halt_line_in,    // output halt input
  input  wire logic                        second_function_line_in, // second function input
  input  wire logic                        thermal_relay_line_in, // thermal relay input
  input  wire logic                        current_setting_line_in, // current setting input
  input  wire logic                        stop_line_in,          // stop self-hold input
  input  wire logic                        speed_select_line_in,  // speed select input
  input  wire logic                        inch_line_in,          // inch input
  input  wire logic                        mode_switch_in,        // request a mode switch
  input  wire logic                        mode_target_ext_in,    // 1 external, 0 keypad
  input  wire logic                        point_write_in,        // write one point
  input  wire logic [4:0]                  point_index_in,        // point 0..29
  input  wire sched_run_pkg::point_entry_t point_entry_in,        // raw entry values
  input  wire logic                        preset_load_in,        // load preset into time
  input  wire sched_run_pkg::tod_t         timer_preset_in,       // preset time value
  output logic                             entry_error_out,       // last entry rejected
  output sched_run_pkg::drive_cmd_t        drive_cmd_out,         // commanded dir and freq
  output logic                             time_up_flag_out,      // schedule completed
  output logic [2:0]                       group_active_out,      // group now running
  output sched_run_pkg::tod_t              ref_time_out,          // reference time of day
  output logic                             monitor_time_out,      // show time not voltage
  output logic                             hour_units_out,        // 1 hour:minute units
  output logic                             external_mode_out,     // 1 external operation
  output logic                             fault_clear_out,       // fault clear, passed in every mode
  output logic                             drive_halt_out,        // halt, passed in every mode
  output logic                             second_function_out,   // second function, passed in every mode
  output logic                             thermal_trip_out,      // thermal relay, passed in every mode
  output logic                             current_setting_out,   // gated current setting
  output logic                             stop_hold_out,         // gated stop
  output logic                             speed_select_out,      // gated speed select
  output logic                             inch_out               // gated inch
);
  import sched_run_pkg::*;

  // =====================================================================
  // declarations
  point_t          point_q [POINTS];
  tod_t            ref_q;
  logic [31:0]     sec_cnt_q;
  logic [5:0]      min_cnt_q;
  logic            sec_tick;
  logic            min_tick;
  logic            step_tick;
  seq_state_t      state_q;
  logic [2:0]      pending_q;
  logic [1:0]      cur_grp_q;
  logic [3:0]      next_pt_q;
  logic            trig_q;
  logic            trig_now;
  logic            clear_now;
  logic            mode_sched;
  logic            start_now;
  logic [4:0]      addr;
  point_t          cur_pt;
  logic            entry_bad;
  logic            set_empty;
  logic            time_empty;
  logic [2:0]      pending_left;
  logic [1:0]      first_grp;
  logic [1:0]      next_grp;

  assign mode_sched = (operating_mode_select_in == MODE_SCHEDULED);
  assign clear_now  = timer_clear_line_in | drive_reset_in | power_loss_in;
  assign trig_now   = program_go_line_in & (|group_select_in);
  // only the rising edge of go-with-group starts, so a run lost to power
  // loss needs go released and reasserted, and then starts over from time zero
  assign start_now  = mode_sched & trig_now & ~trig_q & ~timer_clear_line_in;

  // =====================================================================
  // timebase
  // second tick from the crystal-derived core clock; accuracy is the
  // crystal's own, no trimming is applied
  always_ff @(posedge clk_in) begin
    if (rst_in || sec_tick) begin
      sec_cnt_q <= 32'd0;
    end else begin
      sec_cnt_q <= sec_cnt_q + 32'd1;
    end
  end
  assign sec_tick = (sec_cnt_q == 32'(SEC_CYCLES - 64'd1));

  // minute tick from sixty seconds
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      min_cnt_q <= 6'd0;
    end else if (sec_tick) begin
      min_cnt_q <= (min_cnt_q == 6'(MINOR_PER_MAJOR - 1)) ? 6'd0 : min_cnt_q + 6'd1;
    end
  end
  assign min_tick  = sec_tick & (min_cnt_q == 6'(MINOR_PER_MAJOR - 1));
  assign step_tick = time_unit_select_in[UNIT_HOUR_BIT] ? min_tick : sec_tick;

  // =====================================================================
  // reference time of day
  always_ff @(posedge clk_in) begin
    if (rst_in || clear_now) begin
      ref_q <= TOD_ZERO;
    end else if (start_now) begin
      ref_q <= TOD_ZERO;
    end else if (state_q == ST_RUN && next_pt_q == 4'(GROUP_POINTS) && |pending_left) begin
      ref_q <= TOD_ZERO;
    end else if (preset_load_in && timer_preset_in.minor <= TOD_MINOR_MAX
                 && timer_preset_in.major <= TOD_MAJOR_MAX) begin
      ref_q <= timer_preset_in;
    end else if (step_tick) begin
      // holds at the top instead of wrapping, so a late point never refires
      if (ref_q.minor != TOD_MINOR_MAX) begin
        ref_q.minor <= ref_q.minor + 6'd1;
      end else if (ref_q.major != TOD_MAJOR_MAX) begin
        ref_q.minor <= 6'd0;
        ref_q.major <= ref_q.major + 7'd1;
      end
    end
  end

  // =====================================================================
  // point storage and entry check
  assign set_empty  = (point_entry_in.dir_code == EMPTY_MARK)
                    | (point_entry_in.freq_code == EMPTY_MARK);
  assign time_empty = (point_entry_in.major_code == EMPTY_MARK);
  always_comb begin
    entry_bad = (point_index_in >= 5'(POINTS));
    if (!set_empty) begin
      entry_bad = entry_bad | (point_entry_in.dir_code > DIR_MAX);
      entry_bad = entry_bad | (point_entry_in.freq_code > FREQ_MAX);
    end
    if (!time_empty) begin
      entry_bad = entry_bad | (point_entry_in.minor_code > MINOR_MAX);
      entry_bad = entry_bad | (point_entry_in.major_code > MAJOR_MAX);
    end
  end

  // one store per point; values are kept as typed numbers, so a unit
  // change reinterprets them without rewriting anything
  for (genvar i = 0; i < POINTS; i++) begin : g_point
    always_ff @(posedge clk_in) begin
      if (rst_in) begin
        point_q[i] <= POINT_RESET;
      end else if (point_write_in && !entry_bad && point_index_in == 5'(i)) begin
        point_q[i].set_empty  <= set_empty;
        point_q[i].time_empty <= time_empty;
        point_q[i].dir        <= point_entry_in.dir_code[1:0];
        point_q[i].freq       <= point_entry_in.freq_code[11:0];
        point_q[i].at.major   <= point_entry_in.major_code[6:0];
        point_q[i].at.minor   <= point_entry_in.minor_code[5:0];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      entry_error_out <= 1'b0;
    end else if (point_write_in) begin
      entry_error_out <= entry_bad;
    end else if (preset_load_in) begin
      entry_error_out <= (timer_preset_in.minor > TOD_MINOR_MAX)
                       | (timer_preset_in.major > TOD_MAJOR_MAX);
    end
  end

  // =====================================================================
  // group ordering helpers
  always_comb begin
    first_grp = group_select_in[0] ? 2'd0 : (group_select_in[1] ? 2'd1 : 2'd2);
    pending_left = pending_q;
    pending_left[cur_grp_q] = 1'b0;
    next_grp = pending_left[0] ? 2'd0 : (pending_left[1] ? 2'd1 : 2'd2);
    addr = 5'(cur_grp_q) * 5'(GROUP_POINTS) + 5'(next_pt_q);
    cur_pt = (addr < 5'(POINTS)) ? point_q[addr] : POINT_RESET;
  end

  // =====================================================================
  // sequencer: one point examined per clock, in stored order
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      trig_q <= 1'b0;
    end else begin
      trig_q <= trig_now;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in || clear_now || !mode_sched) begin
      state_q          <= ST_IDLE;
      pending_q        <= 3'd0;
      cur_grp_q        <= 2'd0;
      next_pt_q        <= 4'd0;
      drive_cmd_out    <= '{dir: DIR_STOP, freq: 12'd0};
      time_up_flag_out <= 1'b0;
      group_active_out <= 3'd0;
    end else if (start_now) begin
      state_q          <= ST_RUN;
      pending_q        <= group_select_in;
      cur_grp_q        <= first_grp;
      next_pt_q        <= 4'd0;
      time_up_flag_out <= 1'b0;
      group_active_out <= 3'b001 << first_grp;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
        end
        ST_RUN: begin
          if (next_pt_q == 4'(GROUP_POINTS)) begin
            if (|pending_left) begin
              pending_q        <= pending_left;
              cur_grp_q        <= next_grp;
              next_pt_q        <= 4'd0;
              group_active_out <= 3'b001 << next_grp;
            end else begin
              state_q          <= ST_DONE;
              pending_q        <= 3'd0;
              time_up_flag_out <= 1'b1;
              group_active_out <= 3'd0;
            end
          end else if (cur_pt.set_empty || cur_pt.time_empty) begin
            next_pt_q <= next_pt_q + 4'd1;
          end else if (ref_q >= cur_pt.at) begin
            drive_cmd_out <= '{dir: cur_pt.dir, freq: cur_pt.freq};
            next_pt_q     <= next_pt_q + 4'd1;
          end
        end
        ST_DONE: begin
          // time-up holds until timer clear, drive reset, power loss or a mode change; a new go edge restarts
        end
      endcase
    end
  end

  // =====================================================================
  // mode switching and monitor select
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      external_mode_out <= 1'b0;
    end else if (mode_switch_in && !program_go_line_in && !timer_clear_line_in) begin
      external_mode_out <= mode_target_ext_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ref_time_out     <= TOD_ZERO;
      monitor_time_out <= 1'b0;
      hour_units_out   <= 1'b0;
    end else begin
      ref_time_out     <= ref_q;
      monitor_time_out <= time_unit_select_in[UNIT_MON_BIT];
      hour_units_out   <= time_unit_select_in[UNIT_HOUR_BIT];
    end
  end

  // =====================================================================
  // terminal gating in scheduled mode
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fault_clear_out     <= 1'b0;
      drive_halt_out      <= 1'b0;
      second_function_out <= 1'b0;
      thermal_trip_out    <= 1'b0;
      current_setting_out <= 1'b0;
      stop_hold_out       <= 1'b0;
      speed_select_out    <= 1'b0;
      inch_out            <= 1'b0;
    end else begin
      fault_clear_out     <= fault_clear_line_in;
      drive_halt_out      <= drive_halt_line_in;
      second_function_out <= second_function_line_in;
      thermal_trip_out    <= thermal_relay_line_in;
      current_setting_out <= current_setting_line_in & ~mode_sched;
      stop_hold_out       <= stop_line_in & ~mode_sched;
      speed_select_out    <= speed_select_line_in & ~mode_sched;
      inch_out            <= inch_line_in & ~mode_sched;
    end
  end

endmodule
`default_nettype wire

// File: scheduled_run_sequencer_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// =====================================================
// sequencer bench
module scheduled_run_sequencer_tb_top;
  import sched_run_pkg::*;
  localparam int SEC = 10; // short second keeps runs brief
  logic         clk_in, rst_in, drv_rst, msw, mext, pwr, pld, ploss;
  logic [2:0]   mode;
  logic [1:0]   tunit;
  logic [7:0]   aux;
  logic [4:0]   pidx;
  point_entry_t pent;
  tod_t         preset;
  wire logic    go, clr, err, tup, mon, hour, ext;
  wire logic [2:0] grp, gact;
  wire logic [7:0] aux_o;
  drive_cmd_t   cmd;
  tod_t         rtime;
  int           mismatches, checks_done;
  contact_inputs_model contact_u (.clk_in(clk_in), .go_out(go), .clear_out(clr),
    .group_out(grp));
  scheduled_run_sequencer #(.SEC_CYCLES(SEC)) dut_u (
    .clk_in(clk_in), .rst_in(rst_in), .operating_mode_select_in(mode),
    .time_unit_select_in(tunit), .program_go_line_in(go), .timer_clear_line_in(clr),
    .group_select_in(grp), .drive_reset_in(drv_rst), .power_loss_in(ploss),
    .fault_clear_line_in(aux[0]), .drive_halt_line_in(aux[1]),
    .second_function_line_in(aux[2]), .thermal_relay_line_in(aux[3]),
    .current_setting_line_in(aux[4]), .stop_line_in(aux[5]),
    .speed_select_line_in(aux[6]), .inch_line_in(aux[7]), .mode_switch_in(msw),
    .mode_target_ext_in(mext), .point_write_in(pwr), .point_index_in(pidx),
    .point_entry_in(pent), .preset_load_in(pld), .timer_preset_in(preset),
    .entry_error_out(err), .drive_cmd_out(cmd), .time_up_flag_out(tup),
    .group_active_out(gact), .ref_time_out(rtime), .monitor_time_out(mon),
    .hour_units_out(hour), .external_mode_out(ext), .fault_clear_out(aux_o[0]),
    .drive_halt_out(aux_o[1]), .second_function_out(aux_o[2]),
    .thermal_trip_out(aux_o[3]), .current_setting_out(aux_o[4]),
    .stop_hold_out(aux_o[5]), .speed_select_out(aux_o[6]), .inch_out(aux_o[7]));
  // =====================================================
  // shared helpers
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  function automatic logic [31:0] probe(input int sel);
    case (sel)
      0: return 32'(cmd);
      1: return 32'(tup);
      default: return 32'(gact);
    endcase
  endfunction
  // bounded wait; running out counts as a mismatch and ends the run
  task automatic wait_eq(input string what, input int sel, input logic [31:0] exp,
                         input int lim);
    int n;
    n = 0;
    while (probe(sel) !== exp && n < lim) begin
      @(negedge clk_in);
      n++;
    end
    check(what, exp, probe(sel));
    if (probe(sel) !== exp) begin
      close_out();
    end
  endtask
  // one point write; the strobe drops a full cycle before the next one
  task automatic wr(input logic [4:0] idx, input logic [13:0] d, input logic [13:0] f,
                    input logic [13:0] mi, input logic bad);
    pidx = idx;
    pent = '{dir_code: d, freq_code: f, major_code: 14'd0, minor_code: mi};
    pwr = 1'b1;
    @(negedge clk_in);
    pwr = 1'b0;
    @(negedge clk_in);
    check("entry error", 32'(bad), 32'(err));
  endtask
  // =====================================================
  // scenarios
  task automatic s_entry();
    wr(5'd0, 14'd1, 14'd200, 14'd60, 1'b1);
    wr(5'd0, 14'd3, 14'd200, 14'd2, 1'b1);
    wr(5'd0, 14'd1, 14'd4001, 14'd2, 1'b1);
    wr(5'd0, 14'd1, 14'd200, 14'd2, 1'b0);
    wr(5'd1, 14'd2, 14'd4000, 14'd4, 1'b0);
    wr(5'd2, EMPTY_MARK, 14'd100, 14'd3, 1'b0);
    wr(5'd3, 14'd0, 14'd0, 14'd5, 1'b0);
  endtask
  task automatic s_run();
    contact_u.apply(1'b0, 1'b0, 3'h1);
    contact_u.apply(1'b1, 1'b0, 3'h1);
    @(negedge clk_in);
    check("group active", 32'h1, 32'(gact));
    @(negedge clk_in);
    check("ref at start", 32'h0, 32'(rtime));
    // second tick phase is free running: ten edges after start allow one tick at most
    repeat (9) @(negedge clk_in);
    check("not early", 32'h0, 32'(cmd));
    wait_eq("fwd point", 0, 32'({DIR_FWD, 12'd200}), 40);
    wait_eq("rev point", 0, 32'({DIR_REV, 12'd4000}), 40);
    wait_eq("stop point", 0, 32'h0, 30);
    wait_eq("time up", 1, 32'h1, 30);
    check("group idle", 32'h0, 32'(gact));
    contact_u.apply(1'b0, 1'b0, 3'h0);
  endtask
  task automatic s_clear();
    contact_u.apply(1'b0, 1'b1, 3'h1);
    msw = 1'b1;
    mext = 1'b1;
    @(negedge clk_in);
    msw = 1'b0;
    @(negedge clk_in);
    check("time up cleared", 32'h0, 32'(tup));
    check("ref cleared", 32'h0, 32'(rtime));
    check("switch refused", 32'h0, 32'(ext));
    contact_u.apply(1'b1, 1'b1, 3'h1);
    repeat (3) @(negedge clk_in);
    check("start blocked", 32'h0, 32'(gact));
    contact_u.apply(1'b0, 1'b0, 3'h0);
  endtask
  task automatic s_preset();
    preset = '{major: 7'd99, minor: 6'd59};
    pld = 1'b1;
    @(negedge clk_in);
    pld = 1'b0;
    check("preset error", 32'h0, 32'(err));
    @(negedge clk_in);
    check("preset shown", 32'({7'd99, 6'd59}), 32'(rtime));
    repeat (25) @(negedge clk_in);
    check("ref saturates", 32'({7'd99, 6'd59}), 32'(rtime));
    preset = '{major: 7'd5, minor: 6'd60};
    pld = 1'b1;
    @(negedge clk_in);
    pld = 1'b0;
    check("preset refused", 32'h1, 32'(err));
    drv_rst = 1'b1;
    @(negedge clk_in);
    drv_rst = 1'b0;
    @(negedge clk_in);
    check("drive reset clears", 32'h0, 32'(rtime));
    preset = '{major: 7'd99, minor: 6'd59};
    pld = 1'b1;
    @(negedge clk_in);
    {pld, ploss} = 2'b01;
    @(negedge clk_in);
    ploss = 1'b0;
    @(negedge clk_in);
    check("power loss clears", 32'h0, 32'(rtime));
  endtask
  task automatic s_groups();
    contact_u.apply(1'b1, 1'b0, 3'h5);
    @(negedge clk_in);
    check("first group", 32'h1, 32'(gact));
    wait_eq("third group", 2, 32'h4, 120);
    check("no early time up", 32'h0, 32'(tup));
    @(negedge clk_in);
    check("ref between groups", 32'h0, 32'(rtime));
    wait_eq("time up", 1, 32'h1, 30);
    contact_u.apply(1'b0, 1'b0, 3'h0);
  endtask
  task automatic s_mode();
    aux = 8'hff;
    tunit = 2'h3;
    repeat (2) @(negedge clk_in);
    check("mode 5 gating", 32'h0f, 32'(aux_o));
    check("unit select", 32'h3, 32'({mon, hour}));
    // hour units step once a minute, so 25 cycles move the time by one at most
    preset = TOD_ZERO;
    pld = 1'b1;
    @(negedge clk_in);
    pld = 1'b0;
    repeat (25) @(negedge clk_in);
    check("minute steps", 32'h1, 32'(rtime < 13'd2));
    mode = 3'h0;
    msw = 1'b1;
    @(negedge clk_in);
    msw = 1'b0;
    @(negedge clk_in);
    check("other mode passes", 32'hff, 32'(aux_o));
    check("switch taken", 32'h1, 32'(ext));
  endtask
  // =====================================================
  // clock and main sequence
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  initial begin
    mismatches = 0;
    checks_done = 0;
    rst_in = 1'b1;
    mode = MODE_SCHEDULED;
    tunit = 2'h0;
    {drv_rst, msw, mext, pwr, pld, ploss} = 6'h0;
    aux = 8'h00;
    pidx = 5'h0;
    pent = '0;
    preset = TOD_ZERO;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    rst_in = 1'b0;
    s_entry();
    s_run();
    s_clear();
    s_preset();
    s_groups();
    s_mode();
    close_out();
  end
endmodule
`default_nettype wire
